// ---- core/ccd_buf.sv ----
// ccd_buf: byte store, one write port, one asynchronous read port
// assumes writer and reader share the core clock
`timescale 1ns/1ns
`default_nettype none
module ccd_buf #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem_q [DEPTH];
  // no reset: a fetch as first command sends root bytes read before any write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end
  assign rdata_o = mem_q[raddr_i];
endmodule
`default_nettype wire

// ---- core/ccd_cmd_table.sv ----
// ccd_cmd_table: header to command shape lookup
// assumes a fully captured header; pure combinational
`timescale 1ns/1ns
`default_nettype none
module ccd_cmd_table (
  input  wire ccd_pkg::ccd_hdr_t  hdr_i,
  output var  ccd_pkg::ccd_info_t info_o
);
  import ccd_pkg::*;
  wire p00 = (hdr_i.p1 == 8'h00) && (hdr_i.p2 == 8'h00);
  wire p2z = (hdr_i.p2 == 8'h00);
  always_comb begin
    info_o = '0;
    info_o.known = 1'b1;
    info_o.p_ok  = p00;
    case (hdr_i.ins)
      CCD_INS_UNBLK: begin
        info_o.p_ok    = (hdr_i.p1 == 8'h00) &&
                         (hdr_i.p2 == CCD_P2_PIN1 || hdr_i.p2 == CCD_P2_PIN2);
        info_o.data_in = 1'b1;
        info_o.exp_len = CCD_LEN_UNBLK;
      end
      CCD_INS_DIS, CCD_INS_REEN: info_o.exp_len = 8'h00;
      CCD_INS_RAND: begin
        info_o.exp_len = CCD_LEN_RAND;
        info_o.out_len = CCD_LEN_RAND;
      end
      CCD_INS_AUTH1: begin
        info_o.data_in = 1'b1;
        info_o.exp_len = CCD_LEN_AUTH1;
      end
      CCD_INS_AUTH2: begin
        info_o.data_in = 1'b1;
        info_o.exp_len = CCD_LEN_AUTH2;
        info_o.out_len = CCD_LEN_RES;
      end
      CCD_INS_CKD: begin
        info_o.exp_len = CCD_LEN_RAND;
        info_o.out_len = CCD_LEN_RAND;
      end
      CCD_INS_CKU, CCD_INS_SKS, CCD_INS_GKS: begin
        info_o.p_ok    = p2z;
        info_o.data_in = 1'b1;
        info_o.exp_len = CCD_LEN_KEY;
      end
      CCD_INS_GKU, CCD_INS_SKU, CCD_INS_GSKU: begin
        info_o.data_in = 1'b1;
        info_o.exp_len = CCD_LEN_UNSEAL;
      end
      CCD_INS_MGK: begin
        info_o.p_ok    = (hdr_i.p1 == 8'h00) &&
                         (hdr_i.p2 == CCD_P2_REC1 || hdr_i.p2 == CCD_P2_REC2);
        info_o.data_in = 1'b1;
        info_o.exp_len = CCD_LEN_MGK;
        info_o.out_len = CCD_LEN_RAND;
      end
      CCD_INS_FETCH: info_o.exp_len = 8'h00;
      default: info_o.known = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// ---- core/ccd_core.sv ----
// ccd_core: card command decoder with classic wishbone register slave
// assumes a byte link on clk_i below and firmware on wishbone above
`timescale 1ns/1ns
`default_nettype none
module ccd_core #(
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             fw_req_o
);
  import ccd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  ccd_state_t state_q, state_d;
  ccd_hdr_t   hdr_q;
  ccd_info_t  info;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] sw1_q, sw2_q;
  logic [7:0] cla_q, root_len_q, fetch_len_q;
  logic [23:0] acc_q;
  logic       fetch_av_q, fetch_root_q, fw_done_q, ld_q;
  logic [7:0] tx_q;
  logic [AW-1:0] cmd_ridx_q, rsp_widx_q;
  logic [7:0] ack_q;
  logic       wb_ack_q;
  logic [31:0] wb_dat_q;

  ccd_cmd_table u_tab (
    .hdr_i  (hdr_q),
    .info_o (info)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        wb_req   = wb_cyc_i && wb_stb_i;
  wire        wb_edge  = wb_req && wb_ack_q;
  wire        wb_wr    = wb_edge && wb_we_i && wb_sel_i[0];
  wire        wb_rd    = wb_edge && !wb_we_i;
  wire        wr_ctrl  = wb_wr && (wb_adr_i == CCD_OFS_CTRL);
  wire        wr_root  = wb_wr && (wb_adr_i == CCD_OFS_ROOT);
  wire        wr_acc   = wb_wr && (wb_adr_i == CCD_OFS_ACC);
  wire        wr_res   = wb_wr && (wb_adr_i == CCD_OFS_RES);
  wire        wr_rspd  = wb_wr && (wb_adr_i == CCD_OFS_RSPD);
  wire        wr_ptr   = wb_wr && (wb_adr_i == CCD_OFS_PTR);
  wire        rd_cmdd  = wb_rd && (wb_adr_i == CCD_OFS_CMDD);
  wire        res_go   = wr_res && (state_q == S_FW);
  wire        res_mem  = wb_dat_i[CCD_RES_MEM];
  wire [3:0]  res_try  = wb_dat_i[3:0];

  ////////////////////////////////////////////////////////////////////////
  // buffers
  wire           rx_fire = rx_valid_i && (state_q == S_RXD);
  wire [7:0]     cmd_rd, rsp_rd;
  ccd_buf #(.DEPTH(DEPTH), .AW(AW)) u_cmd (
    .clk_i   (clk_i),
    .we_i    (rx_fire),
    .waddr_i (cnt_q[AW-1:0]),
    .wdata_i (rx_data_i),
    .raddr_i (cmd_ridx_q),
    .rdata_o (cmd_rd)
  );
  ccd_buf #(.DEPTH(DEPTH), .AW(AW)) u_rsp (
    .clk_i   (clk_i),
    .we_i    (wr_rspd),
    .waddr_i (rsp_widx_q),
    .wdata_i (wb_dat_i[7:0]),
    .raddr_i (cnt_q[AW-1:0]),
    .rdata_o (rsp_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // command flow
  wire       is_fetch = (hdr_q.ins == CCD_INS_FETCH);
  wire       send     = (state_q == S_ACK) || (state_q == S_TXD) ||
                        (state_q == S_SW1) || (state_q == S_SW2);
  wire       tx_fire  = tx_valid_o && tx_ready_i;
  wire [7:0] out_n    = is_fetch ? hdr_q.p3 : info.out_len;
  wire       cla_bad  = (hdr_q.cla != cla_q);
  wire       fet_len  = (hdr_q.p3 == 8'h00) || (hdr_q.p3 > fetch_len_q);
  wire       len_bad  = is_fetch ? fet_len : (hdr_q.p3 != info.exp_len);
  wire [7:0] len_fix  = is_fetch ? fetch_len_q : info.exp_len;
  wire       chk_ok   = !cla_bad && info.known && info.p_ok && !len_bad &&
                        !(is_fetch && !fetch_av_q);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      S_HDR: begin
        if (rx_valid_i) begin
          cnt_d = (cnt_q == 8'(CCD_HDR_LAST)) ? 8'h00 : cnt_q + 8'h01;
          if (cnt_q == 8'(CCD_HDR_LAST)) begin
            state_d = S_CHK;
          end
        end
      end
      S_CHK: begin
        if (!chk_ok) begin
          state_d = S_SW1;
        end else if (is_fetch || info.data_in) begin
          state_d = S_ACK;
        end else begin
          state_d = S_FW;
        end
      end
      S_ACK: begin
        if (tx_fire) begin
          state_d = (info.data_in && !fw_done_q) ? S_RXD : S_TXD;
        end
      end
      S_RXD: begin
        if (rx_valid_i) begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == info.exp_len - 8'h01) begin
            state_d = S_FW;
            cnt_d   = 8'h00;
          end
        end
      end
      S_FW: begin
        if (res_go) begin
          state_d = (info.out_len != 8'h00) ? S_ACK : S_SW1;
        end
      end
      S_TXD: begin
        if (tx_fire) begin
          cnt_d = cnt_q + 8'h01;
          if (cnt_q == out_n - 8'h01) begin
            state_d = S_SW1;
            cnt_d   = 8'h00;
          end
        end
      end
      S_SW1: begin
        if (tx_fire) begin
          state_d = S_SW2;
        end
      end
      S_SW2: begin
        if (tx_fire) begin
          state_d = S_HDR;
        end
      end
      default: state_d = S_HDR;
    endcase
  end

  // byte to send; reserved and access fields of root data are forced here
  logic [7:0] tx_byte;
  always_comb begin
    tx_byte = 8'h00;
    case (state_q)
      S_ACK: tx_byte = hdr_q.ins;
      S_TXD: begin
        tx_byte = rsp_rd;
        if (fetch_root_q && is_fetch) begin
          if (cnt_q == CCD_RFU_A || cnt_q == CCD_RFU_B || cnt_q == CCD_RFU_C) begin
            tx_byte = 8'h00;
          end else if (cnt_q == CCD_ACC_B9) begin
            tx_byte = acc_q[23:16];
          end else if (cnt_q == CCD_ACC_B10) begin
            tx_byte = acc_q[15:8];
          end else if (cnt_q == CCD_ACC_B11) begin
            tx_byte = acc_q[7:0];
          end
        end
      end
      S_SW1: tx_byte = sw1_q;
      S_SW2: tx_byte = sw2_q;
      default: tx_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_HDR;
      cnt_q   <= 8'h00;
      hdr_q   <= '0;
      ld_q    <= 1'b0;
      tx_q    <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (state_q == S_HDR && rx_valid_i) begin
        hdr_q <= {hdr_q[31:0], rx_data_i};
      end
      if (tx_fire) begin
        ld_q <= 1'b0;
      end else if (send && !ld_q) begin
        ld_q <= 1'b1;
        tx_q <= tx_byte;
      end
    end
  end
  assign tx_valid_o = send && ld_q;
  assign tx_data_o  = tx_q;
  assign fw_req_o   = (state_q == S_FW);

  ////////////////////////////////////////////////////////////////////////
  // status words and fetch sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw1_q        <= CCD_SW1_OK;
      sw2_q        <= CCD_SW2_NONE;
      fetch_av_q   <= 1'b1;
      fetch_root_q <= 1'b1;
      fetch_len_q  <= CCD_ROOT_LEN;
      fw_done_q    <= 1'b0;
    end else begin
      if (state_q == S_HDR) begin
        fw_done_q <= 1'b0;
      end
      if (state_q == S_CHK) begin
        fetch_av_q <= 1'b0;
        sw2_q      <= CCD_SW2_NONE;
        if (fetch_root_q && !is_fetch) begin
          fetch_root_q <= 1'b0;
        end
        if (cla_bad) begin
          sw1_q <= CCD_SW1_CLA;
        end else if (!info.known) begin
          sw1_q <= CCD_SW1_INS;
        end else if (is_fetch && !fetch_av_q) begin
          sw1_q <= CCD_SW1_TECH;
        end else if (!info.p_ok) begin
          sw1_q <= CCD_SW1_PAR;
        end else if (len_bad) begin
          sw1_q <= CCD_SW1_LEN;
          sw2_q <= len_fix;
        end else begin
          sw1_q <= CCD_SW1_OK;
        end
      end
      if (res_go) begin
        fw_done_q <= 1'b1;
        if (res_mem) begin
          sw1_q <= CCD_SW1_MEM;
          sw2_q <= CCD_SW2_MEMERR;
        end else if (res_try != 4'h0) begin
          sw1_q <= CCD_SW1_MEM;
          sw2_q <= {4'h0, res_try};
        end else if (hdr_q.ins == CCD_INS_AUTH1) begin
          sw1_q       <= CCD_SW1_DATA;
          sw2_q       <= CCD_LEN_RES;
          fetch_av_q  <= 1'b1;
          fetch_len_q <= CCD_LEN_RES;
        end else begin
          sw1_q <= CCD_SW1_OK;
          sw2_q <= CCD_SW2_NONE;
        end
      end
      if (wr_root && fetch_root_q) begin
        fetch_len_q <= wb_dat_i[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register slave
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      CCD_OFS_CTRL: rd_mux = {24'h000000, cla_q};
      CCD_OFS_ROOT: rd_mux = {24'h000000, root_len_q};
      CCD_OFS_ACC:  rd_mux = {8'h00, acc_q};
      CCD_OFS_STAT: rd_mux = {3'h0, state_q, fetch_av_q, fw_req_o,
                              hdr_q.p2, hdr_q.p1, hdr_q.ins};
      CCD_OFS_CMDD: rd_mux = {24'h000000, cmd_rd};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_q   <= 1'b0;
      wb_dat_q   <= 32'h0000_0000;
      cla_q      <= CCD_CLA_RST;
      root_len_q <= CCD_ROOT_LEN;
      acc_q      <= CCD_ACC_RST;
      cmd_ridx_q <= '0;
      rsp_widx_q <= '0;
    end else begin
      wb_ack_q <= wb_req && !wb_ack_q;
      if (wb_req && !wb_ack_q) begin
        wb_dat_q <= rd_mux;
      end
      if (wr_ctrl) begin
        cla_q <= wb_dat_i[7:0];
      end
      if (wr_root) begin
        root_len_q <= wb_dat_i[7:0];
      end
      if (wr_acc) begin
        acc_q <= wb_dat_i[23:0];
      end
      if (wr_ptr) begin
        cmd_ridx_q <= '0;
        rsp_widx_q <= '0;
      end else begin
        if (rd_cmdd) begin
          cmd_ridx_q <= cmd_ridx_q + 1'b1;
        end
        if (wr_rspd) begin
          rsp_widx_q <= rsp_widx_q + 1'b1;
        end
      end
    end
  end
  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_status_pair: assert property (
    (state_q == S_SW1 && tx_fire) |=> (state_q == S_SW2) && !tx_valid_o ##1 tx_valid_o)
    else $error("second status byte not sent after first");
  chk_class_err: assert property (
    (state_q == S_CHK && cla_bad) |=> sw1_q == 8'h6E && sw2_q == 8'h00 && state_q == S_SW1)
    else $error("wrong class not answered 6E 00");
  chk_ins_err: assert property (
    (state_q == S_CHK && !cla_bad && !info.known) |=> sw1_q == 8'h6D && sw2_q == 8'h00)
    else $error("unknown instruction not answered 6D 00");
  chk_fetch_order: assert property (
    (state_q == S_CHK && !cla_bad && is_fetch && !fetch_av_q) |=> sw1_q == 8'h6F)
    else $error("out of order fetch not refused");
  chk_fetch_drop: assert property (
    (state_q == S_CHK && !is_fetch) |=> !fetch_av_q)
    else $error("pending data survived another command");
  chk_mem_fault: assert property (
    (res_go && res_mem) |=> sw1_q == 8'h92 && sw2_q == 8'h40)
    else $error("memory problem not reported 92 40");
  chk_auth_fetch: assert property (
    (res_go && !res_mem && res_try == 4'h0 && hdr_q.ins == 8'h40)
      |=> sw1_q == 8'h9F && sw2_q == 8'h04 && fetch_av_q)
    else $error("first auth result not offered for fetch");
  chk_ok_word: assert property (
    (res_go && !res_mem && res_try == 4'h0 && hdr_q.ins != 8'h40)
      |=> sw1_q == 8'h90 && sw2_q == 8'h00)
    else $error("plain success not 90 00");
  chk_len_err: assert property (
    (state_q == S_CHK && !cla_bad && info.known && !is_fetch && info.p_ok && len_bad)
      |=> sw1_q == 8'h67 && sw2_q == $past(info.exp_len))
    else $error("wrong length not answered with correct length");
  chk_bus_ack: assert property (
    (wb_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");
endmodule
`default_nettype wire

// ---- core/ccd_pkg.sv ----
// ccd_pkg: constants, types and header layout for the card command decoder
// assumes the byte link below it delivers whole bytes on the core clock
// Function
// - pin unblock: INS 2C, P1 00, length 10h, unblock code then new PIN
// - pin unblock P2: 00 first PIN, 02 second PIN
// - disable 04 and re-enable 44: zero parameters, zero length, no data
// - random challenge CE, length 0A, card returns 10 byte challenge
// - first auth 40, length 14: challenge plus seed, 4 byte response
// - second auth 42, length 0E: host response plus seed, 4 bytes back
// - cipher key derivation 46, length 0A, no data in, 10 bytes out
// - common key unseal 48, record in P1, length 11, key plus identifier
// - unseal 4A, 4C, 50 with length 1B: key, version, seed
// - modified group key 4E, length 04, P2 01 or 02, 10 bytes out
// - key store 52 and 54, length 11, P1 names target record
// - fetchable response data only after first auth or selection
// - fetch must follow its command directly, else technical problem
// - fetch allowed as first command, returns root selection data
// - byte bit 8 is most significant, bit 1 least
// - reserved bytes sent as 00, reserved bits as 0
// - access conditions in selection bytes 9 to 11, one nibble each
// - success with no pending data gives 90 00
// - success with pending data gives 9F and the data length
// - write after X retries gives 92 0X, memory problem 92 40
// - wrong class gives 6E 00
// - unknown instruction gives 6D 00
// - wrong length gives 67 with the correct length
// - technical problem status is 6F 00
package ccd_pkg;
  localparam logic [7:0] CCD_CLA_RST    = 8'hA0;
  localparam logic [7:0] CCD_INS_UNBLK  = 8'h2C;
  localparam logic [7:0] CCD_INS_DIS    = 8'h04;
  localparam logic [7:0] CCD_INS_REEN   = 8'h44;
  localparam logic [7:0] CCD_INS_RAND   = 8'hCE;
  localparam logic [7:0] CCD_INS_AUTH1  = 8'h40;
  localparam logic [7:0] CCD_INS_AUTH2  = 8'h42;
  localparam logic [7:0] CCD_INS_CKD    = 8'h46;
  localparam logic [7:0] CCD_INS_CKU    = 8'h48;
  localparam logic [7:0] CCD_INS_GKU    = 8'h4A;
  localparam logic [7:0] CCD_INS_SKU    = 8'h4C;
  localparam logic [7:0] CCD_INS_MGK    = 8'h4E;
  localparam logic [7:0] CCD_INS_GSKU   = 8'h50;
  localparam logic [7:0] CCD_INS_SKS    = 8'h52;
  localparam logic [7:0] CCD_INS_GKS    = 8'h54;
  localparam logic [7:0] CCD_INS_FETCH  = 8'hC0;
  localparam logic [7:0] CCD_LEN_UNBLK  = 8'h10;
  localparam logic [7:0] CCD_LEN_RAND   = 8'h0A;
  localparam logic [7:0] CCD_LEN_AUTH1  = 8'h14;
  localparam logic [7:0] CCD_LEN_AUTH2  = 8'h0E;
  localparam logic [7:0] CCD_LEN_KEY    = 8'h11;
  localparam logic [7:0] CCD_LEN_UNSEAL = 8'h1B;
  localparam logic [7:0] CCD_LEN_MGK    = 8'h04;
  localparam logic [7:0] CCD_LEN_RES    = 8'h04;
  localparam logic [7:0] CCD_P2_PIN1    = 8'h00;
  localparam logic [7:0] CCD_P2_PIN2    = 8'h02;
  localparam logic [7:0] CCD_P2_REC1    = 8'h01;
  localparam logic [7:0] CCD_P2_REC2    = 8'h02;
  localparam logic [7:0] CCD_SW1_OK     = 8'h90;
  localparam logic [7:0] CCD_SW1_DATA   = 8'h9F;
  localparam logic [7:0] CCD_SW1_MEM    = 8'h92;
  localparam logic [7:0] CCD_SW2_MEMERR = 8'h40;
  localparam logic [7:0] CCD_SW1_LEN    = 8'h67;
  localparam logic [7:0] CCD_SW1_PAR    = 8'h6B;
  localparam logic [7:0] CCD_SW1_INS    = 8'h6D;
  localparam logic [7:0] CCD_SW1_CLA    = 8'h6E;
  localparam logic [7:0] CCD_SW1_TECH   = 8'h6F;
  localparam logic [7:0] CCD_SW2_NONE   = 8'h00;
  localparam logic [7:0] CCD_ROOT_LEN   = 8'h16;
  localparam logic [23:0] CCD_ACC_RST   = 24'h000000;
  localparam logic [7:0] CCD_RFU_A      = 8'h00;
  localparam logic [7:0] CCD_RFU_B      = 8'h01;
  localparam logic [7:0] CCD_RFU_C      = 8'h07;
  localparam logic [7:0] CCD_ACC_B9     = 8'h08;
  localparam logic [7:0] CCD_ACC_B10    = 8'h09;
  localparam logic [7:0] CCD_ACC_B11    = 8'h0A;
  localparam logic [7:0] CCD_OFS_CTRL   = 8'h00;
  localparam logic [7:0] CCD_OFS_ROOT   = 8'h04;
  localparam logic [7:0] CCD_OFS_ACC    = 8'h08;
  localparam logic [7:0] CCD_OFS_RES    = 8'h0C;
  localparam logic [7:0] CCD_OFS_STAT   = 8'h10;
  localparam logic [7:0] CCD_OFS_CMDD   = 8'h14;
  localparam logic [7:0] CCD_OFS_RSPD   = 8'h18;
  localparam logic [7:0] CCD_OFS_PTR    = 8'h1C;
  localparam int         CCD_RES_MEM    = 4;
  localparam int         CCD_HDR_LAST   = 4;

  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] p3;
  } ccd_hdr_t;

  typedef struct packed {
    logic       known;
    logic       p_ok;
    logic       data_in;
    logic [7:0] exp_len;
    logic [7:0] out_len;
  } ccd_info_t;

  typedef enum logic [2:0] {
    S_HDR = 3'b000,
    S_CHK = 3'b001,
    S_ACK = 3'b010,
    S_RXD = 3'b011,
    S_FW  = 3'b100,
    S_TXD = 3'b101,
    S_SW1 = 3'b110,
    S_SW2 = 3'b111
  } ccd_state_t;
endpackage

// ---- sim/ccd_term.sv ----
// ccd_term: terminal side of the card byte link, sends bytes and collects replies
// assumes one shared clock; slow makes acceptance of card bytes stall
`timescale 1ns/1ns
`default_nettype none
module ccd_term (
  input  wire logic       clk_i,
  output logic            rx_valid_o,
  output logic      [7:0] rx_data_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  logic       slow;
  logic [1:0] ph_q;
  initial begin
    slow       = 1'b0;
    ph_q       = 2'h0;
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b1;
  end
  //////////////////////////////////////////////////
  // idle data is inverted so a stale byte never passes for a fresh one
  task automatic put(input logic [7:0] b);
    rx_data_o  <= b;
    rx_valid_o <= 1'b1;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~b;
    @(posedge clk_i);
  endtask
  //////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    ph_q       <= ph_q + 2'h1;
    tx_ready_o <= !slow || (ph_q == 2'h3);
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// tb: card command decoder exchanges through the terminal model and wishbone
// assumes firmware answers each result request over wishbone
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ccd_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, res, rx_data_i, tx_data_o, din[0:31], rsp[0:9];
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, fwt[0:2];
  logic        rx_valid_i, tx_valid_o, tx_ready_i, wb_ack_o, fw_req_o, saw_fw;
  logic [55:0] err[0:5];
  logic [39:0] tab[0:10];
  int          n_mismatch = 0, total_checks = 0;
  ccd_core uut (.clk_i(clk_i), .rst_i(rst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fw_req_o(fw_req_o));
  ccd_term term (.clk_i(clk_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
  //////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] sw();
    return {16'h0, term.got[$-1], term.got[$]};
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) n_mismatch++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // data goes in only after the procedure byte; firmware fills replies on request
  task automatic cmd(input logic [39:0] h, input int nin, input int nexp);
    int n;
    n = 0;
    saw_fw = 1'b0;
    term.got.delete();
    for (int i = 4; i >= 0; i--) term.put(h[8*i +: 8]);
    while (term.got.size() < nexp && n < 3000) begin
      if (term.got.size() == 1 && nin > 0) begin
        for (int i = 0; i < nin; i++) term.put(din[i]);
        nin = 0;
      end else if (fw_req_o === 1'b1) begin
        saw_fw = 1'b1;
        wb(1'b1, CCD_OFS_PTR, 32'h0);
        for (int i = 0; i < 10; i++) wb(1'b1, CCD_OFS_RSPD, {24'h0, rsp[i]});
        wb(1'b1, CCD_OFS_RES, {24'h0, res});
      end else begin
        @(posedge clk_i);
        n++;
      end
    end
    repeat (6) @(posedge clk_i);
    chk(32'(term.got.size()), nexp);
  endtask
  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #240000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    res = 8'h00;
    for (int i = 0; i < 32; i++) din[i] = (i < 12) ? 8'(8'h31 + i % 8) : 8'hFF;
    for (int i = 0; i < 10; i++) rsp[i] = 8'(8'h1C + 8'h0B * i);
    err = '{56'hA0C00000046F00, 56'hA2040000006E00, 56'hA0120000006D00,
      56'hA02C0001106B00, 56'hA02C0000086710, 56'hA0440000016700};
    fwt = '{32'h04009000, 32'h44039203, 32'h04109240};
    tab = '{40'hCE000A000D, 40'h46000A000D, 40'h42000E0E08, 40'h4E0104040E, 40'h4E0204040E,
      40'h4800111103, 40'h4A001B1B03, 40'h4C001B1B03, 40'h50001B1B03, 40'h5200111103,
      40'h5400111103};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, CCD_OFS_ACC, 32'h00123456);
    wb(1'b0, CCD_OFS_ACC, 32'h0);
    chk(rd, 32'h00123456);
    wb(1'b0, CCD_OFS_CTRL, 32'h0);
    chk(rd, 32'h000000A0);
    cmd({CCD_CLA_RST, CCD_INS_FETCH, 16'h0, CCD_ROOT_LEN}, 0, 25);
    chk(term.got[1] | term.got[2] | term.got[8], 8'h00);
    chk({term.got[9], term.got[10], term.got[11]}, 32'h123456);
    chk(sw(), 32'h9000);
    for (int i = 0; i < 6; i++) begin
      cmd(err[i][55:16], 0, 2);
      chk(sw(), err[i][15:0]);
    end
    for (int i = 0; i < 3; i++) begin
      res = fwt[i][23:16];
      cmd({CCD_CLA_RST, fwt[i][31:24], 24'h0}, 0, 2);
      chk(saw_fw, 1'b1);
      chk(sw(), fwt[i][15:0]);
    end
    res = 8'h00;
    cmd(40'hA02C000210, 16, 3);
    chk(sw(), 32'h9000);
    wb(1'b1, CCD_OFS_PTR, 32'h0);
    for (int i = 0; i < 16; i++) begin
      wb(1'b0, CCD_OFS_CMDD, 32'h0);
      chk(rd, din[i]);
    end
    cmd(40'hA040000014, 20, 3);
    chk(sw(), 32'h9F04);
    wb(1'b0, CCD_OFS_STAT, 32'h0);
    chk(rd, 32'h02000040);
    cmd(40'hA0C0000004, 0, 7);
    for (int i = 0; i < 4; i++) chk(term.got[i + 1], rsp[i]);
    chk(sw(), 32'h9000);
    for (int i = 0; i < 11; i++) begin
      term.slow = i[0];
      cmd({CCD_CLA_RST, tab[i][39:32], 8'h00, tab[i][31:16]}, int'(tab[i][15:8]), int'(tab[i][7:0]));
      chk(term.got[0], tab[i][39:32]);
      chk(sw(), 32'h9000);
      if (tab[i][7:0] == 8'h0D) for (int j = 0; j < 10; j++) chk(term.got[j + 1], rsp[j]);
      for (int j = 0; j < int'(tab[i][7:0]) - 4; j++)
        if (tab[i][7:0] != 8'h0D) chk(term.got[j + 2], rsp[j]);
    end
    complete_run();
  end
endmodule
`default_nettype wire
